// ### rtl/ulms_defines.vh
// constants for the line and modem status slice
`ifndef ULMS_DEFINES_VH
`define ULMS_DEFINES_VH

// ----------------------------------------------------------------
// register addresses on the host bus
// ----------------------------------------------------------------
`define ULMS_ADDR_RX_HOLD    3'h0
`define ULMS_ADDR_MODEM_CTRL 3'h4
`define ULMS_ADDR_LINE_STAT  3'h5
`define ULMS_ADDR_MODEM_STAT 3'h6
`define ULMS_ADDR_DELAY_HYST 3'h7

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define ULMS_MC_DTR      0
`define ULMS_MC_RTS      1
`define ULMS_MC_OP1      2
`define ULMS_MC_OP2      3
`define ULMS_MC_LOOP     4
`define ULMS_MC_XANY     5
`define ULMS_MC_IR       6
`define ULMS_MC_PRESC    7
`define ULMS_MC_EXT_MASK 8'he0
`define ULMS_MC_RESET    8'h00
`define ULMS_DH_RESET    8'h00
`define ULMS_RD_IDLE     8'h00
`define ULMS_SYNC_RESET  19'h7f800

// ----------------------------------------------------------------
// receive storage: data byte plus three tags
// ----------------------------------------------------------------
`define ULMS_RXF_DEPTH   128
`define ULMS_RXF_AW      7
`define ULMS_CHAR_W      11
`define ULMS_TAG_PE      8
`define ULMS_TAG_FE      9
`define ULMS_TAG_BK      10

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define ULMS_PRESC_LAST  2'h3
`define ULMS_IR_PULSE    4'h3
`define ULMS_IR_STRETCH  4'hf

`endif

// ### rtl/ulms_skid.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`include "ulms_defines.vh"
module ulms_skid #(
  parameter W = `ULMS_CHAR_W
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:1];
  reg         wp;
  reg         rp;
  reg [1:0]   cnt;
  wire        push;
  wire        pop;

  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data  = mem[rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push)
      mem[wp] <= in_data;
  end

  always @(posedge clk) begin
    if (rst) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (push)
        wp <= ~wp;
      if (pop)
        rp <= ~rp;
      if (push & ~pop)
        cnt <= cnt + 2'h1;
      else if (pop & ~push)
        cnt <= cnt - 2'h1;
    end
  end
endmodule // ulms_skid

// ### rtl/ulms_top.v
// line status, modem status and modem control slice of the serial port
`timescale 1ns/1ns
`include "ulms_defines.vh"
module ulms_top (
  input  wire       clk,
  input  wire       rst,
  input  wire       cs_n,
  input  wire       rd_n,
  input  wire       wr_n,
  input  wire [2:0] addr,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe_n,
  input  wire       ext_enable,
  input  wire       ier_line_status,
  input  wire       ier_modem_status,
  input  wire       auto_cts_en,
  input  wire       auto_rts_en,
  input  wire       rs485_auto_en,
  input  wire       trig_table_d,
  input  wire       sw_flow_en,
  input  wire [7:0] rx_trigger,
  input  wire       rx_char_valid,
  input  wire [7:0] rx_char_data,
  input  wire       rx_char_perr,
  input  wire       rx_char_ferr,
  input  wire       rx_char_brk,
  input  wire       rx_char_xonoff,
  input  wire       tx_serial,
  input  wire       tx_fifo_empty,
  input  wire       tx_shift_busy,
  input  wire       bit_tick,
  input  wire       sample_tick,
  input  wire       rx_pin,
  input  wire       cts_n,
  input  wire       dsr_n,
  input  wire       ring_indicator_in_n,
  input  wire       carrier_detect_in_n,
  output reg        rx_serial,
  output reg        tx_pin,
  output reg        rts_n,
  output reg        dtr_n,
  output reg        tx_enable,
  output reg        tx_resume,
  output reg        baud_clk_tick,
  output reg  [5:0] rts_hysteresis,
  output reg        line_irq,
  output reg        modem_irq
);
  localparam S_IDLE  = 2'h0;
  localparam S_SETUP = 2'h1;
  localparam S_SEND  = 2'h2;
  localparam S_HOLD  = 2'h3;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg  [18:0] pin_meta;
  reg  [18:0] pin_s;
  always @(posedge clk) begin
    if (rst) begin
      pin_meta <= `ULMS_SYNC_RESET;
      pin_s    <= `ULMS_SYNC_RESET;
    end else begin
      pin_meta <= {rx_pin, cts_n, dsr_n, ring_indicator_in_n, carrier_detect_in_n,
                   cs_n, rd_n, wr_n, addr, data_in};
      pin_s    <= pin_meta;
    end
  end
  wire       rx_s   = pin_s[18];
  wire [3:0] mpin_s = pin_s[17:14];
  wire       rd_act = ~pin_s[13] & ~pin_s[12];
  wire       wr_act = ~pin_s[13] & ~pin_s[11];
  wire [2:0] a_s    = pin_s[10:8];
  wire [7:0] d_s    = pin_s[7:0];

  // ----------------------------------------------------------------
  // host strobes: read data latched at strobe start, effects at end
  // ----------------------------------------------------------------
  reg       rd_act_d;
  reg       wr_act_d;
  reg [2:0] rd_addr;
  reg [2:0] wr_addr;
  reg [7:0] wr_data;
  wire      rd_start = rd_act & ~rd_act_d;
  wire      rd_end   = ~rd_act & rd_act_d;
  wire      wr_end   = ~wr_act & wr_act_d;
  always @(posedge clk) begin
    if (rst) begin
      rd_act_d <= 1'b0;
      wr_act_d <= 1'b0;
      rd_addr  <= 3'h0;
      wr_addr  <= 3'h0;
      wr_data  <= 8'h00;
    end else begin
      rd_act_d <= rd_act;
      wr_act_d <= wr_act;
      if (rd_start)
        rd_addr <= a_s;
      if (wr_act) begin
        wr_addr <= a_s;
        wr_data <= d_s;
      end
    end
  end
  wire rd_hold = rd_end & (rd_addr == `ULMS_ADDR_RX_HOLD);
  wire rd_line = rd_end & (rd_addr == `ULMS_ADDR_LINE_STAT);
  wire rd_mstat = rd_end & (rd_addr == `ULMS_ADDR_MODEM_STAT);

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  reg [7:0] modem_control;
  reg [7:0] rs485_delay_hysteresis;
  wire [7:0] mc_keep = ext_enable ? 8'h00 : `ULMS_MC_EXT_MASK;
  always @(posedge clk) begin
    if (rst) begin
      modem_control          <= `ULMS_MC_RESET;
      rs485_delay_hysteresis <= `ULMS_DH_RESET;
    end else if (wr_end) begin
      // upper control bits only move with the extended enable
      if (wr_addr == `ULMS_ADDR_MODEM_CTRL)
        modem_control <= (wr_data & ~mc_keep) | (modem_control & mc_keep);
      if (wr_addr == `ULMS_ADDR_DELAY_HYST)
        rs485_delay_hysteresis <= wr_data;
    end
  end
  wire loop_en = modem_control[`ULMS_MC_LOOP];
  wire ir_en   = modem_control[`ULMS_MC_IR];

  // ----------------------------------------------------------------
  // receive path: buffer, then tagged fifo
  // ----------------------------------------------------------------
  reg  brk_lock;
  wire keep_char = ~(rx_char_xonoff & sw_flow_en) & ~(rx_char_brk & brk_lock);
  wire sk_in_valid = rx_char_valid & keep_char;
  wire sk_in_ready;
  wire sk_out_valid;
  wire [`ULMS_CHAR_W-1:0] sk_out_data;
  reg  [`ULMS_CHAR_W-1:0] rxf_mem [0:`ULMS_RXF_DEPTH-1];
  reg  [`ULMS_RXF_AW-1:0] rxf_wp;
  reg  [`ULMS_RXF_AW-1:0] rxf_rp;
  reg  [`ULMS_RXF_AW:0]   rxf_cnt;
  reg  [`ULMS_RXF_AW:0]   rxf_errs;
  wire rxf_full  = rxf_cnt[`ULMS_RXF_AW];
  wire rxf_empty = (rxf_cnt == {(`ULMS_RXF_AW+1){1'b0}});
  wire rxf_push  = sk_out_valid & ~rxf_full;
  wire rxf_pop   = rd_hold & ~rxf_empty;
  wire [`ULMS_CHAR_W-1:0] head = rxf_mem[rxf_rp];
  wire head_tag = |head[`ULMS_TAG_BK:`ULMS_TAG_PE];
  wire push_tag = |sk_out_data[`ULMS_TAG_BK:`ULMS_TAG_PE];

  ulms_skid #(
    .W (`ULMS_CHAR_W)
  ) u_skid (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (sk_in_valid),
    .in_ready  (sk_in_ready),
    .in_data   ({rx_char_brk, rx_char_ferr, rx_char_perr, rx_char_data}),
    .out_valid (sk_out_valid),
    .out_ready (~rxf_full),
    .out_data  (sk_out_data)
  );

  always @(posedge clk) begin
    if (rxf_push)
      rxf_mem[rxf_wp] <= sk_out_data;
  end

  always @(posedge clk) begin
    if (rst) begin
      rxf_wp   <= {`ULMS_RXF_AW{1'b0}};
      rxf_rp   <= {`ULMS_RXF_AW{1'b0}};
      rxf_cnt  <= {(`ULMS_RXF_AW+1){1'b0}};
      rxf_errs <= {(`ULMS_RXF_AW+1){1'b0}};
      brk_lock <= 1'b0;
    end else begin
      if (rxf_push)
        rxf_wp <= rxf_wp + 1'b1;
      if (rxf_pop)
        rxf_rp <= rxf_rp + 1'b1;
      if (rxf_push & ~rxf_pop)
        rxf_cnt <= rxf_cnt + 1'b1;
      else if (rxf_pop & ~rxf_push)
        rxf_cnt <= rxf_cnt - 1'b1;
      // count of tagged entries still stored
      if ((rxf_push & push_tag) & ~(rxf_pop & head_tag))
        rxf_errs <= rxf_errs + 1'b1;
      else if ((rxf_pop & head_tag) & ~(rxf_push & push_tag))
        rxf_errs <= rxf_errs - 1'b1;
      // one break character per low stretch of the line
      if (sk_in_valid & sk_in_ready & rx_char_brk)
        brk_lock <= 1'b1;
      else if (rx_serial)
        brk_lock <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // line status
  // ----------------------------------------------------------------
  reg  overrun;
  reg  thr_empty;
  reg  tx_idle;
  wire ovr_event = sk_in_valid & ~sk_in_ready;
  wire [7:0] line_status = {rxf_errs != {(`ULMS_RXF_AW+1){1'b0}},
                            tx_idle, thr_empty,
                            head[`ULMS_TAG_BK:`ULMS_TAG_PE] & {3{~rxf_empty}},
                            overrun, ~rxf_empty};
  always @(posedge clk) begin
    if (rst) begin
      overrun   <= 1'b0;
      thr_empty <= 1'b1;
      tx_idle   <= 1'b1;
      line_irq  <= 1'b0;
      tx_resume <= 1'b0;
    end else begin
      // a new overrun beats the clearing read
      overrun   <= ovr_event | (overrun & ~rd_line);
      thr_empty <= tx_fifo_empty;
      tx_idle   <= tx_fifo_empty & ~tx_shift_busy;
      line_irq  <= ier_line_status & (overrun | (~rxf_empty & head_tag));
      tx_resume <= modem_control[`ULMS_MC_XANY] & rx_char_valid;
    end
  end

  // ----------------------------------------------------------------
  // modem status and change flags
  // ----------------------------------------------------------------
  wire [3:0] mstat = loop_en ?
                     {modem_control[`ULMS_MC_OP2], modem_control[`ULMS_MC_OP1],
                      modem_control[`ULMS_MC_DTR], modem_control[`ULMS_MC_RTS]} :
                     ~{mpin_s[0], mpin_s[1], mpin_s[2], mpin_s[3]};
  reg  [3:0] mstat_prev;
  reg  [3:0] mdelta;
  reg        mprimed;
  wire [3:0] mchg = (mstat ^ mstat_prev) & {4{mprimed}};
  // ring only reports the end of ringing
  wire [3:0] mset = {mchg[3], mchg[2] & ~mstat[2], mchg[1], mchg[0]};
  wire [7:0] modem_status = {mstat, mdelta};
  always @(posedge clk) begin
    if (rst) begin
      mstat_prev <= 4'h0;
      mdelta     <= 4'h0;
      mprimed    <= 1'b0;
      modem_irq  <= 1'b0;
    end else begin
      mstat_prev <= mstat;
      mprimed    <= 1'b1;
      mdelta     <= mset | (mdelta & {4{~rd_mstat}});
      modem_irq  <= ier_modem_status & (|mdelta);
    end
  end

  // ----------------------------------------------------------------
  // host read data
  // ----------------------------------------------------------------
  reg [7:0] next_rdata;
  always @* begin
    case (a_s)
      `ULMS_ADDR_RX_HOLD:    next_rdata = head[7:0];
      `ULMS_ADDR_MODEM_CTRL: next_rdata = modem_control;
      `ULMS_ADDR_LINE_STAT:  next_rdata = line_status;
      `ULMS_ADDR_MODEM_STAT: next_rdata = modem_status;
      default:               next_rdata = `ULMS_RD_IDLE;
    endcase
  end
  always @(posedge clk) begin
    if (rst) begin
      data_out  <= `ULMS_RD_IDLE;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= ~rd_act;
      if (rd_start)
        data_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // prescaler and infrared codec
  // ----------------------------------------------------------------
  reg [1:0] presc;
  reg [3:0] ir_phase;
  reg [3:0] ir_stretch;
  always @(posedge clk) begin
    if (rst) begin
      presc         <= 2'h0;
      baud_clk_tick <= 1'b0;
      ir_phase      <= 4'h0;
      ir_stretch    <= 4'h0;
      rx_serial     <= 1'b1;
      tx_pin        <= 1'b1;
    end else begin
      presc         <= presc + 2'h1;
      baud_clk_tick <= ~modem_control[`ULMS_MC_PRESC] | (presc == `ULMS_PRESC_LAST);
      if (sample_tick)
        ir_phase <= ir_phase + 4'h1;
      // a received light pulse marks a zero bit for one bit time
      if (rx_s)
        ir_stretch <= `ULMS_IR_STRETCH;
      else if (sample_tick & (ir_stretch != 4'h0))
        ir_stretch <= ir_stretch - 4'h1;
      if (loop_en)
        rx_serial <= tx_serial;
      else if (ir_en)
        rx_serial <= (ir_stretch == 4'h0) & ~rx_s;
      else
        rx_serial <= rx_s;
      // loopback parks the line at mark; infrared idles low
      if (loop_en)
        tx_pin <= 1'b1;
      else if (ir_en)
        tx_pin <= ~tx_serial & (ir_phase < `ULMS_IR_PULSE);
      else
        tx_pin <= tx_serial;
    end
  end

  // ----------------------------------------------------------------
  // rs485 direction sequencing and rts flow control
  // ----------------------------------------------------------------
  reg  [1:0] st;
  reg  [3:0] bit_cnt;
  reg        flow_on;
  reg  [5:0] hyst_lut;
  always @* begin
    case (rs485_delay_hysteresis[3:0])
      4'h1:    hyst_lut = 6'h04;
      4'h2:    hyst_lut = 6'h06;
      4'h3:    hyst_lut = 6'h08;
      4'h4:    hyst_lut = 6'h08;
      4'h5:    hyst_lut = 6'h10;
      4'h6:    hyst_lut = 6'h18;
      4'h7:    hyst_lut = 6'h20;
      4'h8:    hyst_lut = 6'h28;
      4'h9:    hyst_lut = 6'h2c;
      4'ha:    hyst_lut = 6'h30;
      4'hb:    hyst_lut = 6'h34;
      4'hc:    hyst_lut = 6'h0c;
      4'hd:    hyst_lut = 6'h14;
      4'he:    hyst_lut = 6'h1c;
      4'hf:    hyst_lut = 6'h24;
      default: hyst_lut = 6'h00;
    endcase
  end
  wire [5:0] hyst    = (auto_rts_en & trig_table_d) ? hyst_lut : 6'h00;
  wire [8:0] lvl     = {1'b0, rxf_cnt};
  wire [8:0] hi_mark = {1'b0, rx_trigger} + {3'h0, hyst};
  wire [8:0] lo_mark = {1'b0, rx_trigger} - {3'h0, hyst};
  wire       lo_ok   = ({1'b0, rx_trigger} >= {3'h0, hyst}) & (lvl <= lo_mark);
  wire       cts_ok  = ~(auto_cts_en & ~mstat[0]);
  wire       tx_done = tx_fifo_empty & ~tx_shift_busy;

  always @(posedge clk) begin
    if (rst) begin
      st      <= S_IDLE;
      bit_cnt <= 4'h0;
      flow_on <= 1'b1;
    end else begin
      if (lvl >= hi_mark)
        flow_on <= 1'b0;
      else if (lo_ok)
        flow_on <= 1'b1;
      if (~rs485_auto_en)
        st <= S_IDLE;
      else begin
        case (st)
          S_IDLE: begin
            if (~tx_fifo_empty) begin
              st      <= S_SETUP;
              bit_cnt <= rs485_delay_hysteresis[7:4];
            end
          end
          S_SETUP: begin
            if (bit_cnt == 4'h0)
              st <= S_SEND;
            else if (bit_tick)
              bit_cnt <= bit_cnt - 4'h1;
          end
          S_SEND: begin
            if (tx_done) begin
              st      <= S_HOLD;
              bit_cnt <= rs485_delay_hysteresis[3:0];
            end
          end
          S_HOLD: begin
            if (~tx_fifo_empty)
              st <= S_SEND;
            else if (bit_cnt == 4'h0)
              st <= S_IDLE;
            else if (bit_tick)
              bit_cnt <= bit_cnt - 4'h1;
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rts_n          <= 1'b1;
      dtr_n          <= 1'b1;
      tx_enable      <= 1'b1;
      rts_hysteresis <= 6'h00;
    end else begin
      rts_hysteresis <= hyst;
      dtr_n          <= loop_en | ~modem_control[`ULMS_MC_DTR];
      if (loop_en)
        rts_n <= 1'b1;
      else if (rs485_auto_en)
        rts_n <= (st == S_IDLE);
      else if (auto_rts_en)
        rts_n <= ~(modem_control[`ULMS_MC_RTS] & flow_on);
      else
        rts_n <= ~modem_control[`ULMS_MC_RTS];
      // transmitter checks this only between characters
      tx_enable <= cts_ok & (~rs485_auto_en | (st == S_SEND));
    end
  end
endmodule // ulms_top

// ### dv/ulms_props.sv
// assertion checker for the line and modem status slice
`timescale 1ns/1ns
module ulms_props (
  input wire       clk,
  input wire       rst,
  input wire       rx_char_valid,
  input wire       ier_line_status,
  input wire       ier_modem_status,
  input wire       auto_cts_en,
  input wire       auto_rts_en,
  input wire       rs485_auto_en,
  input wire       trig_table_d,
  input wire       cts_n,
  input wire       dtr_n,
  input wire       tx_enable,
  input wire       tx_resume,
  input wire       baud_clk_tick,
  input wire [5:0] rts_hysteresis,
  input wire       line_irq,
  input wire       modem_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_resume_cause: assert property (
    tx_resume |-> $past(rx_char_valid) || $past(rx_char_valid, 2))
    else $error("resume pulse without a received character");
  a_presc_tick: assert property (
    !baud_clk_tick |-> ##[1:4] baud_clk_tick)
    else $error("baud tick gap longer than four cycles");
  a_lirq_gate: assert property (
    line_irq |-> $past(ier_line_status))
    else $error("line interrupt while its enable is low");
  a_mirq_gate: assert property (
    modem_irq |-> $past(ier_modem_status))
    else $error("modem interrupt while its enable is low");
  a_hyst_gated: assert property (
    !(auto_rts_en && trig_table_d) |=> rts_hysteresis == 6'h00)
    else $error("hysteresis shown outside auto rts with table d");
  a_hyst_legal: assert property (
    rts_hysteresis inside {6'h00, 6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18,
                           6'h1c, 6'h20, 6'h24, 6'h28, 6'h2c, 6'h30, 6'h34})
    else $error("hysteresis value not in the table");
  // dtr_n low proves loopback is off, so the status comes from the pin
  a_cts_halt: assert property (
    (auto_cts_en && cts_n && !dtr_n && !rs485_auto_en) [*6] |-> !tx_enable)
    else $error("transmitter not halted by clear-to-send high");
  a_tx_free: assert property (
    (!auto_cts_en && !rs485_auto_en) [*4] |-> tx_enable)
    else $error("transmitter held without flow control");
endmodule // ulms_props

bind ulms_top ulms_props u_props (
  .clk, .rst, .rx_char_valid, .ier_line_status, .ier_modem_status, .auto_cts_en,
  .auto_rts_en, .rs485_auto_en, .trig_table_d, .cts_n, .dtr_n, .tx_enable, .tx_resume,
  .baud_clk_tick, .rts_hysteresis, .line_irq, .modem_irq);

// ### dv/ulms_modem.sv
// far-side modem model driving the active-low modem pins
`timescale 1ns/1ns
module ulms_modem (
  input  wire       clk,
  input  wire [3:0] want,
  output reg        cts_n,
  output reg        dsr_n,
  output reg        ring_indicator_in_n,
  output reg        carrier_detect_in_n,
  output reg        rx_pin
);
  initial begin
    {carrier_detect_in_n, ring_indicator_in_n, dsr_n, cts_n, rx_pin} = 5'h1f;
  end
  // characters reach the receiver side directly, so the line rests at mark
  always @(posedge clk) begin
    {carrier_detect_in_n, ring_indicator_in_n, dsr_n, cts_n} <= ~want;
    rx_pin <= 1'b1;
  end
endmodule // ulms_modem

// ### dv/uart_line_modem_status_tb_top.sv
// self-checking bench for the line and modem status slice
`timescale 1ns/1ns
module uart_line_modem_status_tb_top;
  reg        clk = 1'b0, rst = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  reg  [2:0] addr = 3'h0;
  reg  [7:0] data_in = 8'h00, rx_trigger = 8'h10, rx_char_data = 8'h00;
  reg        ext_enable = 1'b0, ier_line_status = 1'b0, ier_modem_status = 1'b1;
  reg        auto_cts_en = 1'b0, auto_rts_en = 1'b0, rs485_auto_en = 1'b0;
  reg        trig_table_d = 1'b0, sw_flow_en = 1'b0, rx_char_valid = 1'b0;
  reg        rx_char_perr = 1'b0, rx_char_ferr = 1'b0, rx_char_brk = 1'b0;
  reg        rx_char_xonoff = 1'b0, tx_serial = 1'b1, tx_fifo_empty = 1'b1;
  reg        tx_shift_busy = 1'b0, bit_tick = 1'b0, sample_tick = 1'b0, oe_q = 1'b1;
  reg  [3:0] want = 4'h0;
  reg  [1:0] tdiv = 2'h0;
  reg  [15:0] q [$];
  reg  [15:0] ent;
  reg  [7:0] rd_byte [0:139];
  wire       rx_pin, cts_n, dsr_n, ring_indicator_in_n, carrier_detect_in_n, data_oe_n;
  wire       rx_serial, tx_pin, rts_n, dtr_n, tx_enable, tx_resume, baud_clk_tick;
  wire       line_irq, modem_irq;
  wire [7:0] data_out;
  wire [5:0] rts_hysteresis;
  integer    errors = 0, checks = 0, seed = 30921, cyc = 0, nres = 0, nbt = 0, k, n;
  localparam [95:0] HYST = {6'h24, 6'h1c, 6'h14, 6'h0c, 6'h34, 6'h30, 6'h2c, 6'h28,
                            6'h20, 6'h18, 6'h10, 6'h08, 6'h08, 6'h06, 6'h04, 6'h00};

  ulms_top dut (
    .clk, .rst, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe_n, .ext_enable,
    .ier_line_status, .ier_modem_status, .auto_cts_en, .auto_rts_en, .rs485_auto_en,
    .trig_table_d, .sw_flow_en, .rx_trigger, .rx_char_valid, .rx_char_data, .rx_char_perr,
    .rx_char_ferr, .rx_char_brk, .rx_char_xonoff, .tx_serial, .tx_fifo_empty,
    .tx_shift_busy, .bit_tick, .sample_tick, .rx_pin, .cts_n, .dsr_n, .ring_indicator_in_n,
    .carrier_detect_in_n, .rx_serial, .tx_pin, .rts_n, .dtr_n, .tx_enable, .tx_resume,
    .baud_clk_tick, .rts_hysteresis, .line_irq, .modem_irq);
  ulms_modem u_far (.clk, .want, .cts_n, .dsr_n, .ring_indicator_in_n,
                    .carrier_detect_in_n, .rx_pin);

  always #10 clk = ~clk;

  task chk(input string nm, input [7:0] exp, input [7:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  // strobes stay low and high for more than the two synchroniser cycles
  task acc(input w, input [2:0] a, input [7:0] d, input [7:0] m);
    begin
      if (!w) q.push_back({m, d & m});
      addr <= a;
      data_in <= d;
      cs_n <= 1'b0;
      if (w) wr_n <= 1'b0;
      else rd_n <= 1'b0;
      repeat (4) @(posedge clk);
      {cs_n, wr_n, rd_n} <= 3'h7;
      repeat (5) @(posedge clk);
    end
  endtask

  task burst(input integer cnt, input [2:0] tg);
    integer j;
    begin
      for (j = 0; j < cnt; j = j + 1) begin
        n = $random(seed);
        rd_byte[j] = n[7:0];
        rx_char_valid <= 1'b1;
        rx_char_data <= n[7:0];
        {rx_char_brk, rx_char_ferr, rx_char_perr} <= (j == 0) ? tg : 3'h0;
        @(posedge clk);
      end
      rx_char_valid <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask

  // aligned to a bit tick so no tick falls on the mode change
  task ticks(input hold, output integer c);
    integer j;
    begin
      c = 0;
      while (!bit_tick) @(posedge clk);
      tx_fifo_empty <= hold;
      for (j = 0; j < 300; j = j + 1) begin
        @(posedge clk);
        if (bit_tick && !rts_n && (hold || !tx_enable)) c = c + 1;
        if (hold ? rts_n : (tx_enable && !rts_n)) j = 300;
      end
    end
  endtask

  task end_of_test;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    nres <= nres + tx_resume;
    nbt <= nbt + baud_clk_tick;
    tdiv <= tdiv + 2'h1;
    bit_tick <= (tdiv == 2'h3);
    sample_tick <= ~sample_tick;
    oe_q <= data_oe_n;
    if (oe_q && !data_oe_n && q.size() > 0) begin
      ent = q.pop_front();
      if (ent[15:8] != 8'h00) chk("read data", ent[7:0], data_out & ent[15:8]);
    end
    if (cyc == 40000) begin
      errors = errors + 1;
      end_of_test;
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    acc(0, 3'h4, 8'h00, 8'hff);
    acc(0, 3'h6, 8'h00, 8'hff);
    acc(0, 3'h7, 8'h00, 8'hff);
    acc(0, 3'h1, 8'h00, 8'hff);
    for (k = 0; k < 3; k = k + 1) begin
      {tx_fifo_empty, tx_shift_busy} <= k[1:0] ^ 2'h2;
      @(posedge clk);
      acc(0, 3'h5, (k == 0) ? 8'h60 : (k == 1) ? 8'h20 : 8'h00, 8'h60);
    end
    {tx_fifo_empty, tx_shift_busy} <= 2'h2;
    $display("reset and transmit flags done");
    acc(1, 3'h4, 8'hff, 8'h00);
    acc(0, 3'h4, 8'h1f, 8'hff);
    acc(0, 3'h6, 8'hf0, 8'hf0);
    chk("dtr in loopback", 8'h01, {7'h0, dtr_n});
    acc(1, 3'h4, 8'h15, 8'h00);
    acc(0, 3'h6, 8'h60, 8'hf0);
    tx_serial <= 1'b0;
    repeat (3) @(posedge clk);
    chk("loop rx", 8'h00, {7'h0, rx_serial});
    chk("loop tx", 8'h01, {7'h0, tx_pin});
    tx_serial <= 1'b1;
    ext_enable <= 1'b1;
    acc(1, 3'h4, 8'ha1, 8'h00);
    acc(0, 3'h4, 8'ha1, 8'hff);
    chk("dtr out", 8'h00, {7'h0, dtr_n});
    n = nbt;
    repeat (40) @(posedge clk);
    chk("div4 ticks", 8'h0a, nbt - n);
    k = nres;
    burst(1, 3'h0);
    chk("resume pulses", 8'h01, nres - k);
    acc(0, 3'h0, rd_byte[0], 8'hff);
    sw_flow_en <= 1'b1;
    rx_char_xonoff <= 1'b1;
    burst(1, 3'h0);
    {sw_flow_en, rx_char_xonoff} <= 2'h0;
    chk("resume pulses", 8'h02, nres - k);
    acc(0, 3'h5, 8'h60, 8'hff);
    acc(1, 3'h4, 8'h41, 8'h00);
    chk("ir idle", 8'h00, {7'h0, tx_pin});
    acc(1, 3'h4, 8'h01, 8'h00);
    chk("plain idle", 8'h01, {7'h0, tx_pin});
    n = nbt;
    repeat (40) @(posedge clk);
    chk("div1 ticks", 8'h28, nbt - n);
    $display("control bits done");
    ier_line_status <= 1'b1;
    for (k = 1; k < 5; k = k * 2) begin
      burst(2, k[2:0]);
      chk("line irq", 8'h01, {7'h0, line_irq});
      acc(0, 3'h5, 8'he1 | (k[7:0] << 2), 8'hff);
      acc(0, 3'h0, rd_byte[0], 8'hff);
      acc(0, 3'h5, 8'h61, 8'hff);
      acc(0, 3'h0, rd_byte[1], 8'hff);
      acc(0, 3'h5, 8'h60, 8'hff);
    end
    burst(135, 3'h0);
    chk("overrun irq", 8'h01, {7'h0, line_irq});
    acc(0, 3'h5, 8'h03, 8'h03);
    acc(0, 3'h5, 8'h01, 8'h03);
    for (k = 0; k < 135; k = k + 1) acc(0, 3'h0, rd_byte[k], (k < 130) ? 8'hff : 8'h00);
    acc(0, 3'h5, 8'h60, 8'hff);
    $display("receive status done");
    acc(0, 3'h6, 8'h00, 8'h00);
    for (k = 0; k < 4; k = k + 1) begin
      want[k] <= 1'b1;
      repeat (6) @(posedge clk);
      acc(0, 3'h6, (8'h10 << k) | ((k == 2) ? 8'h00 : (8'h01 << k)), 8'hff);
      acc(0, 3'h6, 8'h10 << k, 8'hff);
      want[k] <= 1'b0;
      repeat (6) @(posedge clk);
      chk("modem irq", 8'h01, {7'h0, modem_irq});
      acc(0, 3'h6, 8'h01 << k, 8'hff);
    end
    auto_cts_en <= 1'b1;
    repeat (8) @(posedge clk);
    chk("cts halt", 8'h00, {7'h0, tx_enable});
    want[0] <= 1'b1;
    repeat (8) @(posedge clk);
    chk("cts resume", 8'h01, {7'h0, tx_enable});
    {auto_cts_en, want[0]} <= 2'h0;
    $display("modem status done");
    {auto_rts_en, trig_table_d} <= 2'h3;
    for (k = 0; k < 16; k = k + 1) begin
      acc(1, 3'h7, k[7:0], 8'h00);
      chk("hysteresis", {2'h0, HYST[k*6 +: 6]}, {2'h0, rts_hysteresis});
    end
    trig_table_d <= 1'b0;
    repeat (3) @(posedge clk);
    chk("hysteresis off", 8'h00, {2'h0, rts_hysteresis});
    acc(1, 3'h4, 8'h03, 8'h00);
    chk("auto rts on", 8'h00, {7'h0, rts_n});
    burst(16, 3'h0);
    chk("auto rts off", 8'h01, {7'h0, rts_n});
    auto_rts_en <= 1'b0;
    acc(1, 3'h7, 8'h32, 8'h00);
    rs485_auto_en <= 1'b1;
    repeat (6) @(posedge clk);
    chk("rs485 idle", 8'h01, {7'h0, rts_n});
    ticks(1'b0, n);
    chk("setup ticks", 8'h03, n[7:0]);
    ticks(1'b1, n);
    chk("hold ticks", 8'h02, n[7:0]);
    $display("rs485 and hysteresis done");
    end_of_test;
  end
endmodule // uart_line_modem_status_tb_top
